// >>> secu_scan_unit.sv
// top: per-scan execution condition unit with edge and refresh handling
`timescale 1ns/1ps
`default_nettype none
module secu_scan_unit #(
  parameter int unsigned SLOTS = secu_pkg::SLOTS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire secu_pkg::secu_req_t req,
  output secu_pkg::secu_rsp_t rsp,
  output logic [SLOTS-1:0] prev_flags
);
  localparam int unsigned SW = $clog2(SLOTS);
  logic [SLOTS-1:0] rise_map_ff;
  logic [SLOTS-1:0] nxt_rise_map;
  logic [SLOTS-1:0] wr_en;
  logic [SLOTS-1:0] wr_val;
  logic cur_prev;
  logic ev_exec;
  logic ev_flow;
  secu_pkg::secu_rsp_t rsp_ff;
  secu_pkg::secu_rsp_t nxt_rsp;
  logic is_edge;
  logic evaluated;

  assign is_edge = req.cfg.edge_kind != secu_pkg::SECU_PLAIN;
  // interlocked or jumped instructions are not evaluated at all
  assign evaluated = req.valid && req.active;

  // the slot kind is remembered so the preset follows the instruction's marker
  always_comb begin
    nxt_rise_map = rise_map_ff;
    if (req.valid && is_edge) begin
      nxt_rise_map[req.slot] = req.cfg.edge_kind == secu_pkg::SECU_RISE;
    end
  end

  secu_prev_store #(.SLOTS(SLOTS)) u_store (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .rise_slot(nxt_rise_map),
    .wr_en(wr_en),
    .wr_val(wr_val),
    .prev(prev_flags)
  );

  assign cur_prev = prev_flags[req.slot];

  always_comb begin
    wr_en = '0;
    wr_val = '0;
    if (evaluated && is_edge) begin
      wr_en[req.slot] = 1'b1;
      wr_val[req.slot] = req.cond;
    end
  end

  secu_eval u_eval (
    .cfg(req.cfg),
    .cond(req.cond),
    .prev(cur_prev),
    .execute(ev_exec),
    .flow(ev_flow)
  );

  always_comb begin
    nxt_rsp = '0;
    nxt_rsp.valid = req.valid;
    nxt_rsp.slot = req.slot;
    if (evaluated) begin
      nxt_rsp.execute = ev_exec;
      nxt_rsp.flow = ev_flow;
      nxt_rsp.refresh_in = req.cfg.immediate && (ev_exec || !req.cfg.is_output);
      nxt_rsp.refresh_out = req.cfg.immediate && ev_exec;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_map_ff <= '0;
      rsp_ff <= '0;
    end else begin
      rise_map_ff <= nxt_rise_map;
      rsp_ff <= nxt_rsp;
    end
  end

  assign rsp = rsp_ff;

  logic [SW-1:0] slot_d;
  assign slot_d = req.slot;

  a_rise_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_RISE && req.cfg.is_output && cur_prev)
    |=> !rsp.execute) else $error("rising output fired with prev on");
  a_fall_exec: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_FALL && req.cfg.is_output
     && cur_prev && !req.cond) |=> rsp.execute) else $error("falling output missed");
  a_plain_out: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_PLAIN && req.cfg.is_output)
    |=> rsp.execute == $past(req.cond)) else $error("plain output wrong");
  a_plain_in: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_PLAIN && !req.cfg.is_output
     && !req.cfg.inverted) |=> rsp.flow == $past(req.cond)) else $error("plain input wrong");
  a_rise_in: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_RISE && !req.cfg.is_output
     && !req.cfg.inverted) |=> rsp.flow == ($past(req.cond) && !$past(cur_prev)))
    else $error("rising input wrong");
  a_inv_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_RISE && !req.cfg.is_output
     && req.cfg.inverted && req.cond && !cur_prev) |=> !rsp.flow)
    else $error("inverted rising input wrong");
  a_fall_in: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_FALL && !req.cfg.is_output
     && !req.cfg.inverted && !req.cond && cur_prev) |=> rsp.flow)
    else $error("falling input missed");
  a_inv_fall: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.edge_kind == secu_pkg::SECU_FALL && !req.cfg.is_output
     && req.cfg.inverted && req.cond) |=> rsp.flow) else $error("inverted falling wrong");
  a_prev_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && !req.active && is_edge)
    |=> prev_flags[$past(slot_d)] == $past(cur_prev))
    else $error("prev flag changed while skipped");
  a_prev_upd: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && is_edge) |=> prev_flags[$past(slot_d)] == $past(req.cond))
    else $error("prev flag not updated");

  // helper views for the rising and falling output checks
  logic rise_out;
  logic fall_out;
  assign rise_out = evaluated && req.cfg.edge_kind == secu_pkg::SECU_RISE && req.cfg.is_output;
  assign fall_out = evaluated && req.cfg.edge_kind == secu_pkg::SECU_FALL && req.cfg.is_output;

  sequence s_rise_edge;
    rise_out && req.cond && !cur_prev;
  endsequence

  sequence s_rise_again;
    rise_out && req.cond;
  endsequence

  a_rise_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_rise_edge ##2 s_rise_again |=> !rsp.execute)
    else $error("rising output fired twice");
  a_fall_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (fall_out && !req.cond && !cur_prev) |=> !rsp.execute)
    else $error("falling output fired without edge");
  a_skip_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && !req.active) |=> (rsp.valid && !rsp.execute && !rsp.flow
     && !rsp.refresh_in && !rsp.refresh_out))
    else $error("skipped instruction produced a result");
  a_slot_echo: assert property (@(posedge ref_clk) disable iff (!reset_n)
    req.valid |=> (rsp.valid && rsp.slot == $past(slot_d)))
    else $error("response slot or valid wrong");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !req.valid |=> (!rsp.valid && !rsp.execute && !rsp.flow))
    else $error("response without request");
  a_refresh_out: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.immediate && req.cfg.is_output)
    |=> rsp.refresh_out == rsp.execute)
    else $error("output refresh mismatch");
  a_refresh_in: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (evaluated && req.cfg.immediate && !req.cfg.is_output) |=> rsp.refresh_in)
    else $error("input refresh missing");
endmodule : secu_scan_unit
`default_nettype wire

// >>> secu_pkg.sv
// package of constants and carrier types for the scan edge condition unit
package secu_pkg;
  localparam int unsigned SLOTS = 8;
  localparam logic PREV_RISE_INIT = 1'h1;
  localparam logic PREV_FALL_INIT = 1'h0;

  typedef enum logic [1:0] {
    SECU_PLAIN = 2'b00,
    SECU_RISE = 2'b01,
    SECU_FALL = 2'b10
  } secu_edge_t;

  typedef struct packed {
    secu_edge_t edge_kind;
    logic is_output;
    logic inverted;
    logic immediate;
  } secu_cfg_t;

  typedef struct packed {
    logic valid;
    logic [$clog2(SLOTS)-1:0] slot;
    secu_cfg_t cfg;
    logic cond;
    logic active;
  } secu_req_t;

  typedef struct packed {
    logic valid;
    logic [$clog2(SLOTS)-1:0] slot;
    logic execute;
    logic flow;
    logic refresh_in;
    logic refresh_out;
  } secu_rsp_t;
endpackage : secu_pkg

// >>> secu_prev_store.sv
// previous-value flags, one per edge instruction slot
`timescale 1ns/1ps
`default_nettype none
module secu_prev_store #(
  parameter int unsigned SLOTS = secu_pkg::SLOTS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [SLOTS-1:0] rise_slot,
  input wire logic [SLOTS-1:0] wr_en,
  input wire logic [SLOTS-1:0] wr_val,
  output logic [SLOTS-1:0] prev
);
  logic [SLOTS-1:0] prev_ff;
  logic [SLOTS-1:0] nxt_prev;
  logic [SLOTS-1:0] start_ff;
  logic [SLOTS-1:0] nxt_start;

  // a slot keeps reading its preset until its first write, since its kind
  // only becomes known with its first request
  always_comb begin
    nxt_start = start_ff;
    nxt_prev = prev_ff;
    for (int i = 0; i < SLOTS; i++) begin
      if (wr_en[i]) begin
        nxt_prev[i] = wr_val[i];
        nxt_start[i] = 1'b1;
      end else if (!start_ff[i]) begin
        nxt_prev[i] = rise_slot[i] ? secu_pkg::PREV_RISE_INIT : secu_pkg::PREV_FALL_INIT;
      end else begin
        nxt_prev[i] = prev_ff[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= '0;
      start_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
      start_ff <= nxt_start;
    end
  end

  // until the slot's first write, report the preset value so the first scan stays quiet
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      prev[i] = start_ff[i] ? prev_ff[i] :
                (rise_slot[i] ? secu_pkg::PREV_RISE_INIT : secu_pkg::PREV_FALL_INIT);
    end
  end
endmodule : secu_prev_store
`default_nettype wire

// >>> secu_eval.sv
// combinational evaluation of one instruction's execution result
`timescale 1ns/1ps
`default_nettype none
module secu_eval (
  input wire secu_pkg::secu_cfg_t cfg,
  input wire logic cond,
  input wire logic prev,
  output logic execute,
  output logic flow
);
  logic pulse;
  always_comb begin
    unique case (cfg.edge_kind)
      secu_pkg::SECU_RISE: pulse = cond && !prev;
      secu_pkg::SECU_FALL: pulse = !cond && prev;
      default: pulse = cond;
    endcase
    execute = cfg.is_output & pulse;
    flow = cfg.is_output ? 1'b0 : (pulse ^ cfg.inverted);
  end
endmodule : secu_eval
`default_nettype wire

// >>> secu_scan_unit_tb_top.sv
// self-checking testbench for the scan edge condition unit
`timescale 1ns/1ps
`default_nettype none
module secu_scan_unit_tb_top;
  localparam secu_pkg::secu_edge_t k_pl = secu_pkg::SECU_PLAIN;
  localparam secu_pkg::secu_edge_t k_ri = secu_pkg::SECU_RISE;
  localparam secu_pkg::secu_edge_t k_fa = secu_pkg::SECU_FALL;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  secu_pkg::secu_req_t req = '0;
  secu_pkg::secu_rsp_t rsp;
  logic [7:0] prev_flags;
  int miscompares = 0;
  int checks = 0;

  secu_scan_unit #(.SLOTS(8)) dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .req(req),
    .rsp(rsp),
    .prev_flags(prev_flags)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic finish_test;
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one request, then an idle edge so the same request is never evaluated twice
  task automatic step(input logic [2:0] s, input secu_pkg::secu_edge_t k, input logic o,
                      input logic i, input logic a, input logic c, input logic e);
    @(posedge ref_clk);
    req <= '{valid: 1'h1, slot: s, cond: c, active: a,
             cfg: '{edge_kind: k, is_output: o, inverted: i, immediate: 1'h1}};
    @(posedge ref_clk);
    req.valid <= 1'h0;
    #1;
    chk("valid", 8'h01, {7'h0, rsp.valid});
    chk("slot", {5'h0, s}, {5'h0, rsp.slot});
    if (o) chk("execute", {7'h0, e}, {7'h0, rsp.execute});
    else chk("flow", {7'h0, e}, {7'h0, rsp.flow});
    chk("refresh_in", {7'h0, a & (e | ~o)}, {7'h0, rsp.refresh_in});
    if (a && k != k_pl) chk("prev", {7'h0, c}, {7'h0, prev_flags[s]});
  endtask : step

  task automatic t_plain;
    step(3'h0, k_pl, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    step(3'h0, k_pl, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    step(3'h0, k_pl, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h0, k_pl, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    step(3'h0, k_pl, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
  endtask : t_plain

  task automatic t_rise;
    step(3'h1, k_ri, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    step(3'h1, k_ri, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h1, k_ri, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    step(3'h1, k_ri, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    step(3'h2, k_ri, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h2, k_ri, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    step(3'h2, k_ri, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    step(3'h3, k_ri, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
    step(3'h3, k_ri, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
    step(3'h3, k_ri, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
  endtask : t_rise

  task automatic t_fall;
    step(3'h4, k_fa, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h4, k_fa, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    step(3'h4, k_fa, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    step(3'h4, k_fa, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h5, k_fa, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h5, k_fa, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    step(3'h5, k_fa, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    step(3'h5, k_fa, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h6, k_fa, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
    step(3'h6, k_fa, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    step(3'h6, k_fa, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
  endtask : t_fall

  // skipped or interlocked evaluation must leave the stored value alone
  task automatic t_hold;
    step(3'h7, k_ri, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    step(3'h7, k_ri, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    chk("prev_held", 8'h00, {7'h0, prev_flags[7]});
    step(3'h7, k_ri, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    step(3'h7, k_ri, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    chk("prev_held", 8'h01, {7'h0, prev_flags[7]});
    step(3'h7, k_ri, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
  endtask : t_hold

  initial begin
    repeat (2000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    chk("rsp_reset", 8'h00, rsp);
    chk("flags_reset", 8'h00, prev_flags);
    reset_n <= 1'h1;
    t_plain();
    t_rise();
    t_fall();
    t_hold();
    finish_test();
  end
endmodule : secu_scan_unit_tb_top
`default_nettype wire
